// ### cwd_defines.vh
// Constants for the configuration word decoder
`ifndef CWD_DEFINES_VH
`define CWD_DEFINES_VH
`define CWD_ADDR_LOW_FIRST   16'hfe00
`define CWD_ADDR_LOW_LAST    16'hfe07
`define CWD_ADDR_HIGH_FIRST  16'hfe08
`define CWD_ADDR_HIGH_LAST   16'hfe0f
`define CWD_LOW_RESET        16'hffff
`define CWD_HIGH_RESET       16'hffff
`define CWD_LOW_MASK         16'h005f
`define CWD_HIGH_MASK        16'h00c0
`define CWD_BIT_MODE2        7
`define CWD_BIT_BROWNOUT     6
`define CWD_BIT_MODE1        6
`define CWD_BIT_MODE0        4
`define CWD_BIT_WDPS1        3
`define CWD_BIT_WDPS0        2
`define CWD_BIT_OSC1         1
`define CWD_BIT_OSC0         0
`define CWD_MODE_MICROPROC   3'h7
`define CWD_MODE_MICROCTRL   3'h6
`define CWD_MODE_EXTENDED    3'h5
`define CWD_MODE_PROTECTED   3'h0
`define CWD_OSC_EXTERNAL     2'h3
`define CWD_OSC_CRYSTAL      2'h2
`define CWD_OSC_RC           2'h1
`define CWD_OSC_LOWFREQ      2'h0
`define CWD_WDPS_1           2'h3
`define CWD_WDPS_256         2'h2
`define CWD_WDPS_64          2'h1
`define CWD_WDPS_OFF         2'h0
`define CWD_POWERUP_MS       96
`define CWD_CLK_MHZ          200
`define CWD_POWERUP_CYCLES   (`CWD_POWERUP_MS * 1000 * `CWD_CLK_MHZ)
`define CWD_OSC_STARTUP_CYC  1024
`define CWD_CYCLE_PHASES     4
`endif

// ### cwd_hold_timer.v
// Reset-hold down counter
`timescale 1ns/1ps
module cwd_hold_timer #(
  parameter WIDTH = 32
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             start,
  input  wire [WIDTH-1:0] loadValue,
  input  wire             tick,
  output reg              busy
);
  reg [WIDTH-1:0] count_reg;

  always @(posedge clk) begin
    if (reset) begin
      count_reg <= {WIDTH{1'b0}};
      busy      <= 1'b0;
    end else if (start) begin
      count_reg <= loadValue;
      busy      <= (loadValue != {WIDTH{1'b0}});
    end else if (busy && tick) begin
      count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      busy      <= (count_reg != {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end
endmodule // cwd_hold_timer

// ### cwd_config_decode.v
// Configuration word decoder with reset hold, sleep wake and cycle phases
`timescale 1ns/1ps
`include "cwd_defines.vh"
module cwd_config_decode #(
  parameter POWERUP_CYCLES     = `CWD_POWERUP_CYCLES,
  parameter OSC_STARTUP_CYCLES = `CWD_OSC_STARTUP_CYC
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        powerOnEvent,
  input  wire        brownoutDetect,
  input  wire        externalReset,
  input  wire        watchdogTimeout,
  input  wire        interruptRequest,
  input  wire        sleepRequest,
  input  wire        watchdogRcTick,
  input  wire        configWrite,
  input  wire [15:0] configWriteData,
  input  wire        tableRead,
  input  wire [15:0] tableAddr,
  output reg  [15:0] tableReadData,
  output reg         tableReadValid,
  output reg  [2:0]  memMode,
  output reg         brownoutEnable,
  output reg         brownoutReset,
  output reg         watchdogEnable,
  output reg  [8:0]  watchdogPostscale,
  output reg  [1:0]  oscType,
  output reg         chipHeldInReset,
  output reg         sleeping,
  output reg  [1:0]  cyclePhase,
  output reg         instrCycleStrobe
);
  reg  [15:0] configWordLow_reg;
  reg  [15:0] configWordHigh_reg;
  reg  [1:0]  phase_reg;
  wire        powerupBusy;
  wire        oscStartupBusy;
  wire        brownoutFire;
  wire        oscStart;
  wire [2:0]  modeBits;
  wire [1:0]  postBits;
  wire        addrInLow;
  wire        addrInHigh;
  wire        wakeEvent;
  wire        holdRequest;
  wire [1:0]  phase_next;

  // Inclusive bounds on both ends
  function inRange;
    input [15:0] addr;
    input [15:0] first;
    input [15:0] last;
    begin
      inRange = (addr >= first) && (addr <= last);
    end
  endfunction

  assign modeBits = {configWordHigh_reg[`CWD_BIT_MODE2], configWordLow_reg[`CWD_BIT_MODE1],
                     configWordLow_reg[`CWD_BIT_MODE0]};
  assign postBits = {configWordLow_reg[`CWD_BIT_WDPS1], configWordLow_reg[`CWD_BIT_WDPS0]};
  assign brownoutFire = brownoutDetect && configWordHigh_reg[`CWD_BIT_BROWNOUT];
  assign oscStart = powerOnEvent || brownoutFire;
  // Both halves decoded once, shared by write and read
  assign addrInLow  = inRange(tableAddr, `CWD_ADDR_LOW_FIRST, `CWD_ADDR_LOW_LAST);
  assign addrInHigh = inRange(tableAddr, `CWD_ADDR_HIGH_FIRST, `CWD_ADDR_HIGH_LAST);

  // Programming stores both halves; unprogrammed bits erase to one
  always @(posedge clk) begin
    if (reset) begin
      configWordLow_reg  <= `CWD_LOW_RESET;
      configWordHigh_reg <= `CWD_HIGH_RESET;
    end else if (configWrite && addrInLow) begin
      configWordLow_reg  <= configWriteData | ~(`CWD_LOW_MASK);
    end else if (configWrite && addrInHigh) begin
      configWordHigh_reg <= configWriteData | ~(`CWD_HIGH_MASK);
    end
  end

  // Table read by address range
  // Valid answers every request, so a miss still completes
  always @(posedge clk) begin
    if (reset) begin
      tableReadData  <= 16'h0000;
      tableReadValid <= 1'b0;
    end else begin
      tableReadValid <= tableRead;
      if (tableRead && addrInLow)
        tableReadData <= configWordLow_reg;
      else if (tableRead && addrInHigh)
        tableReadData <= configWordHigh_reg;
      else if (tableRead)
        tableReadData <= 16'h0000;
    end
  end

  // Decoded outputs, all registered
  always @(posedge clk) begin
    if (reset) begin
      memMode           <= `CWD_MODE_MICROPROC;
      brownoutEnable    <= 1'b1;
      brownoutReset     <= 1'b0;
      oscType           <= `CWD_OSC_EXTERNAL;
    end else begin
      // Mode decode, undefined codes fall back to protected
      case (modeBits)
        `CWD_MODE_MICROPROC: memMode <= `CWD_MODE_MICROPROC;
        `CWD_MODE_MICROCTRL: memMode <= `CWD_MODE_MICROCTRL;
        `CWD_MODE_EXTENDED:  memMode <= `CWD_MODE_EXTENDED;
        default:             memMode <= `CWD_MODE_PROTECTED;
      endcase
      brownoutEnable <= configWordHigh_reg[`CWD_BIT_BROWNOUT];
      brownoutReset  <= brownoutFire;
      oscType <= {configWordLow_reg[`CWD_BIT_OSC1], configWordLow_reg[`CWD_BIT_OSC0]};
    end
  end

  // No software path, only config bits
  always @(posedge clk) begin
    if (reset) begin
      watchdogEnable    <= 1'b1;
      watchdogPostscale <= 9'h001;
    end else begin
      case (postBits)
        `CWD_WDPS_1: begin
          watchdogEnable    <= 1'b1;
          watchdogPostscale <= 9'h001;
        end
        `CWD_WDPS_256: begin
          watchdogEnable    <= 1'b1;
          watchdogPostscale <= 9'h100;
        end
        `CWD_WDPS_64: begin
          watchdogEnable    <= 1'b1;
          watchdogPostscale <= 9'h040;
        end
        default: begin
          watchdogEnable    <= 1'b0;
          watchdogPostscale <= 9'h000;
        end
      endcase
    end
  end

  // Holds count main clocks; the RC tick input is left unconnected
  // Power-up delay, power-on only
  cwd_hold_timer #(
    .WIDTH(32)
  ) powerupTimer (
    .clk      (clk),
    .reset    (reset),
    .start    (powerOnEvent),
    .loadValue(POWERUP_CYCLES),
    .tick     (1'b1),
    .busy     (powerupBusy)
  );

  // Level start reloads the count while brown-out persists
  // Oscillator start-up hold on power-on and brown-out
  cwd_hold_timer #(
    .WIDTH(32)
  ) oscStartupTimer (
    .clk      (clk),
    .reset    (reset),
    .start    (oscStart),
    .loadValue(OSC_STARTUP_CYCLES),
    .tick     (1'b1),
    .busy     (oscStartupBusy)
  );

  // Start pulses counted too, so no gap before busy rises
  assign holdRequest = powerupBusy || oscStartupBusy || oscStart || externalReset;
  // Timeout wakes only while the watchdog is enabled
  assign wakeEvent = externalReset || (watchdogTimeout && watchdogEnable) || interruptRequest;

  // Hold and sleep state
  always @(posedge clk) begin
    if (reset) begin
      chipHeldInReset <= 1'b1;
      sleeping        <= 1'b0;
    end else begin
      chipHeldInReset <= holdRequest;
      // Wake sources win over a sleep request
      if (wakeEvent)
        sleeping <= 1'b0;
      else if (sleepRequest)
        sleeping <= 1'b1;
    end
  end

  // Four clock phases per instruction cycle
  // Phase restarts at zero after every hold or sleep
  assign phase_next = phase_reg + 2'h1;
  always @(posedge clk) begin
    if (reset || chipHeldInReset || sleeping) begin
      phase_reg        <= 2'h0;
      cyclePhase       <= 2'h0;
      instrCycleStrobe <= 1'b0;
    end else begin
      phase_reg        <= phase_next;
      cyclePhase       <= phase_reg;
      instrCycleStrobe <= (phase_reg == 2'h3);
    end
  end
endmodule // cwd_config_decode

// ### cwd_decode_checker.sv
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
module cwd_decode_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        tableRead,
  input wire logic [15:0] tableAddr,
  input wire logic [15:0] tableReadData,
  input wire logic        tableReadValid,
  input wire logic [2:0]  memMode,
  input wire logic        brownoutDetect,
  input wire logic        brownoutEnable,
  input wire logic        brownoutReset,
  input wire logic        watchdogEnable,
  input wire logic [8:0]  watchdogPostscale,
  input wire logic        powerOnEvent,
  input wire logic        chipHeldInReset,
  input wire logic        sleeping,
  input wire logic        externalReset,
  input wire logic        interruptRequest,
  input wire logic [1:0]  cyclePhase,
  input wire logic        instrCycleStrobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence rdReq; tableRead; endsequence
  // Eight is the floor of any start-up count in use
  sequence heldRun; chipHeldInReset [*8]; endsequence
  a_read_answered: assert property (rdReq |=> tableReadValid)
    else $error("read not answered");
  a_unmapped_zero: assert property (rdReq ##0 (tableAddr < 16'hfe00 || tableAddr > 16'hfe0f)
    |=> tableReadData == 16'h0000) else $error("unmapped read not zero");
  a_mode_legal: assert property (memMode inside {3'h7, 3'h6, 3'h5, 3'h0})
    else $error("illegal memory mode");
  a_wdt_off_zero: assert property (!watchdogEnable |-> watchdogPostscale == 9'h000)
    else $error("disabled watchdog has postscale");
  a_strobe_gap: assert property (instrCycleStrobe |=> !instrCycleStrobe [*3])
    else $error("strobe closer than four clocks");
  a_phase_last: assert property (instrCycleStrobe |-> cyclePhase == 2'h3)
    else $error("strobe outside last phase");
  a_bor_follow: assert property (brownoutDetect && brownoutEnable |=> brownoutReset)
    else $error("brown-out reset missing");
  a_bor_hold: assert property ($rose(brownoutReset) |-> ##[0:2] chipHeldInReset)
    else $error("brown-out did not hold chip");
  a_sleep_wake: assert property (sleeping && (externalReset || interruptRequest) |=> !sleeping)
    else $error("sleep not left");
  a_power_hold: assert property (powerOnEvent |=> heldRun)
    else $error("power-up hold too short");
endmodule // cwd_decode_checker
bind cwd_config_decode cwd_decode_checker u_chk (.clk, .reset, .tableRead, .tableAddr, .tableReadData,
  .tableReadValid, .memMode, .brownoutDetect, .brownoutEnable, .brownoutReset, .watchdogEnable,
  .watchdogPostscale, .powerOnEvent, .chipHeldInReset, .sleeping, .externalReset, .interruptRequest,
  .cyclePhase, .instrCycleStrobe);

// ### test_config_word_decode.sv
// Self-checking bench for the decoder
`timescale 1ns/1ps
module test_config_word_decode;
  logic clk = 0, reset = 1, powerOnEvent = 0, brownoutDetect = 0, externalReset = 0;
  logic watchdogTimeout = 0, interruptRequest = 0, sleepRequest = 0, watchdogRcTick = 0;
  logic configWrite = 0, tableRead = 0, tableReadValid, brownoutEnable, brownoutReset;
  logic watchdogEnable, chipHeldInReset, sleeping, instrCycleStrobe;
  logic [15:0] configWriteData = 0, tableAddr = 0, tableReadData;
  logic [2:0] memMode;
  logic [8:0] watchdogPostscale;
  logic [1:0] oscType, cyclePhase;
  logic [8:0] ps [4] = '{9'h000, 9'h040, 9'h100, 9'h001};
  int bad_count = 0, checks = 0, n;
  // Short counts keep the run brief
  cwd_config_decode #(.POWERUP_CYCLES(50), .OSC_STARTUP_CYCLES(8)) dut (.clk, .reset, .powerOnEvent,
    .brownoutDetect, .externalReset, .watchdogTimeout, .interruptRequest, .sleepRequest, .watchdogRcTick,
    .configWrite, .configWriteData, .tableRead, .tableAddr, .tableReadData, .tableReadValid, .memMode,
    .brownoutEnable, .brownoutReset, .watchdogEnable, .watchdogPostscale, .oscType, .chipHeldInReset,
    .sleeping, .cyclePhase, .instrCycleStrobe);
  initial forever #2.5 clk = ~clk;
  task chk(input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [15:0] a, d);
    @(posedge clk) tableAddr <= a;
    configWriteData <= d;
    configWrite <= 1;
    @(posedge clk) configWrite <= 0;
    @(posedge clk) #1;
  endtask
  task rd(input logic [15:0] a, exp);
    @(posedge clk) tableAddr <= a;
    tableRead <= 1;
    @(posedge clk) tableRead <= 0;
    #1 chk(tableReadValid, 16'h1);
    chk(tableReadData, exp);
  endtask
  // Wake source applied one cycle, then sleep state compared
  task nap(input logic [2:0] src, input logic [15:0] expSleep);
    @(posedge clk) sleepRequest <= 1;
    @(posedge clk) sleepRequest <= 0;
    @(posedge clk) {externalReset, interruptRequest, watchdogTimeout} <= src;
    @(posedge clk) {externalReset, interruptRequest, watchdogTimeout} <= 3'h0;
    @(posedge clk) #1 chk(sleeping, expSleep);
  endtask
  task hold_len;
    n = 0;
    #1;
    while (chipHeldInReset !== 1'b0 && n < 200) begin
      @(posedge clk) #1 n++;
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000 bad_count++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 0;
    @(posedge clk) #1 chk({memMode, oscType, watchdogPostscale}, 16'h3e01);
    rd(16'hfe00, 16'hffff);
    rd(16'hfe0f, 16'hffff);
    rd(16'hfe10, 16'h0000);
    rd(16'hfdff, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(16'hfe03, 16'hffd0 | 16'(i * 5));
      chk(oscType, 16'(i));
      chk(watchdogPostscale, ps[i]);
      chk(watchdogEnable, 16'(i != 0));
      rd(16'hfe05, 16'hfff0 | 16'(i * 5));
    end
    for (int m = 0; m < 8; m++) begin
      wr(16'hfe08, m[2] ? 16'hffff : 16'hff7f);
      wr(16'hfe00, 16'hffaf | 16'(m[1]) << 6 | 16'(m[0]) << 4);
      chk(memMode, (m > 4 && m < 8) ? 16'(m) : 16'h0);
    end
    $display("test decode done");
    nap(3'h1, 16'h0);
    nap(3'h2, 16'h0);
    nap(3'h4, 16'h0);
    wr(16'hfe00, 16'hfff3);
    nap(3'h1, 16'h1);
    nap(3'h2, 16'h0);
    $display("test sleep done");
    wr(16'hfe08, 16'hffbf);
    @(posedge clk) brownoutDetect <= 1;
    repeat (3) @(posedge clk);
    #1 chk({brownoutEnable, brownoutReset, chipHeldInReset}, 16'h0);
    wr(16'hfe08, 16'hffff);
    chk({brownoutEnable, brownoutReset, chipHeldInReset}, 16'h7);
    @(posedge clk) brownoutDetect <= 0;
    hold_len;
    chk(16'(n > 4 && n < 40), 16'h1);
    @(posedge clk) powerOnEvent <= 1;
    @(posedge clk) powerOnEvent <= 0;
    hold_len;
    chk(16'(n > 47 && n < 54), 16'h1);
    $display("test hold done");
    n = 0;
    repeat (40) begin
      @(posedge clk) #1 n += instrCycleStrobe;
      if (instrCycleStrobe === 1'b1) chk(cyclePhase, 16'h3);
    end
    chk(16'(n), 16'ha);
    $display("test cycle done");
    wrap_up;
  end
endmodule // test_config_word_decode
